// ==== hdl/mlr_readout.sv ====
// Four-lane serial readout of the four-channel converter results
`default_nettype none
module mlr_readout (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic serial_clk_i,
   input wire logic convert_strobe_n_i,
   input wire logic rate_select_pin_i,
   input wire logic lvds_select_pin_i,
   input wire logic [mlr_pkg::BUS_W-1:0] chan_data_i,
   output logic sample_o,
   output logic convert_o,
   output logic result_valid_o,
   output logic busy_o,
   output logic early_strobe_o,
   output logic lane_out_1_o,
   output logic lane_out_2_o,
   output logic lane_out_3_o,
   output logic lane_out_4_o,
   output logic diff_lane_a_o,
   output logic diff_lane_b_o,
   output logic diff_lane_c_o,
   output logic diff_lane_d_o,
   output logic forwarded_clock_o
);
   import mlr_pkg::*;

   // Refuse constant sets that the counters and lane map cannot serve
   if (CONV_CYC < 1 || CONV_CYC > (1 << CNT_W)) begin : g_chk_cnt
      $error("conversion count does not fit its counter");
   end
   if ((1 << SLOT_W) != BUS_W) begin : g_chk_slot
      $error("slot counter must span one full lane rotation");
   end
   if (CHAN_N != 4 || WORD_W != 16) begin : g_chk_map
      $error("lane map assumes four sixteen-bit words");
   end

   // System clock domain

   logic strobe_s1_q;
   logic strobe_s1_d;
   logic strobe_s2_q;
   logic strobe_s2_d;
   logic strobe_s3_q;
   logic strobe_s3_d;
   logic strobe_rise;
   logic strobe_fall;

   // Two stages tame the asynchronous pin; the third is edge history
   always_comb begin
      strobe_s1_d = convert_strobe_n_i;
      strobe_s2_d = strobe_s1_q;
      strobe_s3_d = strobe_s2_q;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strobe_s1_q <= 1'b1;
         strobe_s2_q <= 1'b1;
         strobe_s3_q <= 1'b1;
      end else begin
         strobe_s1_q <= strobe_s1_d;
         strobe_s2_q <= strobe_s2_d;
         strobe_s3_q <= strobe_s3_d;
      end
   end

   // Edge of the synchronised strobe towards the given level
   function automatic logic edge_to(input logic now_v, input logic was_v,
                                    input logic level);
      return (now_v == level) && (was_v != level);
   endfunction

   assign strobe_rise = edge_to(strobe_s2_q, strobe_s3_q, 1'b1);
   assign strobe_fall = edge_to(strobe_s2_q, strobe_s3_q, 1'b0);

   mlr_state_t state_q;
   mlr_state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [BUS_W-1:0] result_q;
   logic [BUS_W-1:0] result_d;
   logic sample_q;
   logic sample_d;
   logic convert_q;
   logic convert_d;
   logic valid_q;
   logic valid_d;
   logic busy_q;
   logic busy_d;
   logic early_q;
   logic early_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      result_d = result_q;
      sample_d = 1'b0;
      convert_d = 1'b0;
      valid_d = 1'b0;
      busy_d = busy_q;
      early_d = early_q;
      case (state_q)
         ST_IDLE: begin
            if (strobe_rise) begin
               sample_d = 1'b1;
               state_d = ST_ACQ;
            end
         end
         ST_ACQ: begin
            if (strobe_fall) begin
               convert_d = 1'b1;
               busy_d = 1'b1;
               cnt_d = CNT_W'(CONV_CYC - 1);
               state_d = ST_CONV;
            end
         end
         ST_CONV: begin
            // A new strobe mid-conversion is flagged; result still lands
            if (strobe_rise) begin
               early_d = 1'b1;
            end
            if (cnt_q == '0) begin
               // Results stay fixed until the next conversion ends
               result_d = chan_data_i;
               valid_d = 1'b1;
               busy_d = 1'b0;
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         default: begin
            state_d = ST_IDLE;
            busy_d = 1'b0;
         end
      endcase
      if (valid_d && !early_d) begin
         early_d = 1'b0;
      end else if (state_q == ST_IDLE && strobe_rise) begin
         early_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         result_q <= '0;
         sample_q <= 1'b0;
         convert_q <= 1'b0;
         valid_q <= 1'b0;
         busy_q <= 1'b0;
         early_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         result_q <= result_d;
         sample_q <= sample_d;
         convert_q <= convert_d;
         valid_q <= valid_d;
         busy_q <= busy_d;
         early_q <= early_d;
      end
   end

   assign sample_o = sample_q;
   assign convert_o = convert_q;
   assign result_valid_o = valid_q;
   assign busy_o = busy_q;
   assign early_strobe_o = early_q;

   // Serial clock domain
   // The serial clock may stop between frames, so the slot counters are
   // cleared by the strobe itself while it is high rather than by edges.
   // result_q is read here unsynchronised: it only changes a conversion
   // time after the strobe falls, before the host may clock any bit.

   logic frame_rst_n;
   assign frame_rst_n = arst_n_i & ~convert_strobe_n_i;

   logic rate_s1_q;
   logic rate_s1_d;
   logic rate_s2_q;
   logic rate_s2_d;
   logic io_s1_q;
   logic io_s1_d;
   logic io_s2_q;
   logic io_s2_d;

   // Straps move only while the strobe holds the lanes cleared
   always_comb begin
      rate_s1_d = rate_select_pin_i;
      rate_s2_d = rate_s1_q;
      io_s1_d = lvds_select_pin_i;
      io_s2_d = io_s1_q;
   end

   always_ff @(negedge serial_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rate_s1_q <= RATE_SDR;
         rate_s2_q <= RATE_SDR;
         io_s1_q <= IO_CMOS;
         io_s2_q <= IO_CMOS;
      end else begin
         rate_s1_q <= rate_s1_d;
         rate_s2_q <= rate_s2_d;
         io_s1_q <= io_s1_d;
         io_s2_q <= io_s2_d;
      end
   end

   logic ddr;
   assign ddr = (rate_s2_q == RATE_DDR);

   logic [SLOT_W-1:0] fall_cnt_q;
   logic [SLOT_W-1:0] fall_cnt_d;
   logic [SLOT_W-1:0] rise_cnt_q;
   logic [SLOT_W-1:0] rise_cnt_d;
   logic [SLOT_W-1:0] edges;
   logic [SLOT_W-1:0] slot_fall;

   // Slot counters wrap at 64 so the circular order repeats forever
   always_comb begin
      fall_cnt_d = fall_cnt_q + SLOT_ONE;
      rise_cnt_d = rise_cnt_q + SLOT_ONE;
      edges = fall_cnt_q + rise_cnt_q;
      if (ddr) begin
         slot_fall = edges;
      end else begin
         slot_fall = fall_cnt_q;
      end
   end

   always_ff @(negedge serial_clk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         fall_cnt_q <= '0;
      end else begin
         fall_cnt_q <= fall_cnt_d;
      end
   end

   always_ff @(posedge serial_clk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         rise_cnt_q <= '0;
      end else begin
         rise_cnt_q <= rise_cnt_d;
      end
   end

   logic [CHAN_N-1:0] lane_bit;

   // Lane k starts with channel k, then follows the circular order
   for (genvar k = 0; k < CHAN_N; k++) begin : g_lane
      mlr_lane_shift #(
         .LANE(2'(k))
      ) u_lane (
         .sck_i(serial_clk_i),
         .frame_rst_n_i(frame_rst_n),
         .ddr_i(ddr),
         .slot_fall_i(slot_fall),
         .slot_rise_i(edges),
         .words_i(result_q),
         .lane_o(lane_bit[k])
      );
   end

   // Unused pin set stays low so its receiver never sees stray edges
   function automatic logic pin_drive(input logic io_now,
                                      input logic io_want,
                                      input logic bit_v);
      return (io_now == io_want) & bit_v;
   endfunction

   assign lane_out_1_o = pin_drive(io_s2_q, IO_CMOS, lane_bit[0]);
   assign lane_out_2_o = pin_drive(io_s2_q, IO_CMOS, lane_bit[1]);
   assign lane_out_3_o = pin_drive(io_s2_q, IO_CMOS, lane_bit[2]);
   assign lane_out_4_o = pin_drive(io_s2_q, IO_CMOS, lane_bit[3]);
   assign diff_lane_a_o = pin_drive(io_s2_q, IO_LVDS, lane_bit[0]);
   assign diff_lane_b_o = pin_drive(io_s2_q, IO_LVDS, lane_bit[1]);
   assign diff_lane_c_o = pin_drive(io_s2_q, IO_LVDS, lane_bit[2]);
   assign diff_lane_d_o = pin_drive(io_s2_q, IO_LVDS, lane_bit[3]);

   // Forwarded clock rebuilt from two edge flops, so it carries the same
   // launch delay as the lanes and can serve as the capture clock.
   logic fwd_rise_q;
   logic fwd_rise_d;
   logic fwd_fall_q;
   logic fwd_fall_d;

   always_comb begin
      fwd_rise_d = ~fwd_fall_q;
      fwd_fall_d = fwd_rise_q;
   end

   always_ff @(posedge serial_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fwd_rise_q <= 1'b0;
      end else begin
         fwd_rise_q <= fwd_rise_d;
      end
   end

   always_ff @(negedge serial_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fwd_fall_q <= 1'b0;
      end else begin
         fwd_fall_q <= fwd_fall_d;
      end
   end

   assign forwarded_clock_o = fwd_rise_q ^ fwd_fall_q;
endmodule
`default_nettype wire

// ==== include/mlr_pkg.sv ====
// Constants and helpers for the multi-lane serial readout
`default_nettype none
package mlr_pkg;
   localparam int unsigned CHAN_N = 4;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned SLOT_W = 6;
   localparam int unsigned BUS_W = CHAN_N * WORD_W;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned CONV_TIME_NS = 200;
   localparam int unsigned CONV_CYC =
      (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam logic RATE_SDR = 1'b0;
   localparam logic RATE_DDR = 1'b1;
   localparam logic IO_CMOS = 1'b0;
   localparam logic IO_LVDS = 1'b1;
   localparam logic [SLOT_W-1:0] SLOT_ONE = 6'h01;
   localparam int unsigned CNT_W = 8;

   typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} mlr_state_t;

   // Word layout: channel c occupies bits [c*16+15 : c*16]
   function automatic logic pick_bit(input logic [BUS_W-1:0] w,
                                     input logic [1:0] lane,
                                     input logic [SLOT_W-1:0] slot);
      logic [1:0] chan;
      chan = lane + slot[5:4];
      return w[{chan, ~slot[3:0]}];
   endfunction
endpackage
`default_nettype wire

// ==== hdl/mlr_lane_shift.sv ====
// One serial lane: channel selection and dual-edge output stage
`default_nettype none
module mlr_lane_shift #(
   parameter logic [1:0] LANE = 2'h0
) (
   input wire logic sck_i,
   input wire logic frame_rst_n_i,
   input wire logic ddr_i,
   input wire logic [mlr_pkg::SLOT_W-1:0] slot_fall_i,
   input wire logic [mlr_pkg::SLOT_W-1:0] slot_rise_i,
   input wire logic [mlr_pkg::BUS_W-1:0] words_i,
   output logic lane_o
);
   import mlr_pkg::*;

   logic fall_q;
   logic fall_d;
   logic rise_q;
   logic rise_d;

   // Output is fall_q ^ rise_q; the fall flop stores the wanted level xored
   // with rise_q, and in DDR the rise flop does the same with fall_q, so either edge can set the pin.
   always_comb begin
      fall_d = pick_bit(words_i, LANE, slot_fall_i) ^ rise_q;
   end

   always_ff @(negedge sck_i or negedge frame_rst_n_i) begin
      if (!frame_rst_n_i) begin
         fall_q <= 1'b0;
      end else begin
         fall_q <= fall_d;
      end
   end

   always_comb begin
      if (ddr_i) begin
         rise_d = pick_bit(words_i, LANE, slot_rise_i) ^ fall_q;
      end else begin
         rise_d = rise_q;
      end
   end

   always_ff @(posedge sck_i or negedge frame_rst_n_i) begin
      if (!frame_rst_n_i) begin
         rise_q <= 1'b0;
      end else begin
         rise_q <= rise_d;
      end
   end

   assign lane_o = fall_q ^ rise_q;
endmodule
`default_nettype wire

// ==== bench/mlr_readout_monitor.sv ====
// Port assertions for the serial readout
`default_nettype none
module mlr_readout_monitor (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic convert_strobe_n_i,
   input wire logic lvds_select_pin_i,
   input wire logic sample_o,
   input wire logic convert_o,
   input wire logic result_valid_o,
   input wire logic busy_o,
   input wire logic lane_out_1_o,
   input wire logic lane_out_2_o,
   input wire logic lane_out_3_o,
   input wire logic lane_out_4_o,
   input wire logic diff_lane_a_o,
   input wire logic diff_lane_b_o,
   input wire logic diff_lane_c_o,
   input wire logic diff_lane_d_o
);
   wire [3:0] cm = {lane_out_4_o, lane_out_3_o, lane_out_2_o, lane_out_1_o};
   wire [3:0] df = {diff_lane_d_o, diff_lane_c_o, diff_lane_b_o,
      diff_lane_a_o};
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_sample;
      $rose(convert_strobe_n_i) && !busy_o |-> ##[1:4] sample_o;
   endproperty
   a_sample: assert property (p_sample)
      else $error("no sample pulse");
   property p_busy;
      convert_o |-> busy_o;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy low at convert");
   property p_valid;
      convert_o |-> ##50 result_valid_o;
   endproperty
   a_valid: assert property (p_valid)
      else $error("result late or early");
   property p_busy_end;
      $fell(busy_o) |-> result_valid_o;
   endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("busy dropped early");
   property p_pulse;
      sample_o || convert_o |=> !sample_o && !convert_o;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("pulse too long");
   property p_idle;
      convert_strobe_n_i |-> cm == 4'h0 && df == 4'h0;
   endproperty
   a_idle: assert property (p_idle)
      else $error("lanes active while strobe high");
   property p_cmos_off;
      lvds_select_pin_i |-> cm == 4'h0;
   endproperty
   a_cmos_off: assert property (p_cmos_off)
      else $error("single-ended lanes active");
   property p_diff_off;
      !lvds_select_pin_i |-> df == 4'h0;
   endproperty
   a_diff_off: assert property (p_diff_off)
      else $error("differential lanes active");
endmodule
bind mlr_readout mlr_readout_monitor mlr_readout_monitor_inst (
   .clk_i(clk_i), .arst_n_i(arst_n_i),
   .convert_strobe_n_i(convert_strobe_n_i),
   .lvds_select_pin_i(lvds_select_pin_i), .sample_o(sample_o),
   .convert_o(convert_o), .result_valid_o(result_valid_o),
   .busy_o(busy_o), .lane_out_1_o(lane_out_1_o),
   .lane_out_2_o(lane_out_2_o), .lane_out_3_o(lane_out_3_o),
   .lane_out_4_o(lane_out_4_o), .diff_lane_a_o(diff_lane_a_o),
   .diff_lane_b_o(diff_lane_b_o), .diff_lane_c_o(diff_lane_c_o),
   .diff_lane_d_o(diff_lane_d_o));
`default_nettype wire

// ==== bench/mlr_host_model.sv ====
// Host capture model: shifts lanes in on forwarded clock edges
`default_nettype none
module mlr_host_model (
   input wire logic fwd_clk_i,
   input wire logic ddr_i,
   input wire logic clr_i,
   input wire logic [3:0] lane_i,
   output logic [255:0] cap_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Late sampling: data and clock leave the device aligned
   always @(fwd_clk_i or posedge clr_i) begin
      if (clr_i) begin
         cap_o = '0;
      end else if (ddr_i || fwd_clk_i) begin
         #10;
         for (int k = 0; k < 4; k++) begin
            cap_o[k*64 +: 64] = {cap_o[k*64 +: 63], lane_i[k]};
         end
      end
   end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the serial readout
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   n_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import mlr_pkg::*;
   typedef struct {logic ddr; logic lvds; logic [63:0] d;} mlr_row_t;
   mlr_row_t rows[4] = '{'{1'b0, 1'b0, 64'h0123456789abcdef},
      '{1'b1, 1'b0, 64'hfedcba9876543210},
      '{1'b1, 1'b1, 64'h80017ffea5a55a5a},
      '{1'b0, 1'b1, 64'hffff0000c3c33c3c}};
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic sclk = 1'b0;
   logic strobe_n = 1'b0;
   logic ddr = 1'b0;
   logic lvds = 1'b0;
   logic clr = 1'b1;
   logic seen;
   logic [63:0] data = '0;
   logic [63:0] e;
   wire smp, convert_strobe_n, vld, busy, early, fwd;
   wire [3:0] cm, df;
   wire [255:0] cap;
   wire [3:0] watch = {early, vld, convert_strobe_n, smp};
   wire [13:0] quiet = {smp, convert_strobe_n, vld, busy, early, fwd, cm, df};
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   mlr_readout mlr_readout_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .serial_clk_i(sclk), .convert_strobe_n_i(strobe_n),
      .rate_select_pin_i(ddr), .lvds_select_pin_i(lvds),
      .chan_data_i(data), .sample_o(smp), .convert_o(convert_strobe_n),
      .result_valid_o(vld), .busy_o(busy), .early_strobe_o(early),
      .lane_out_1_o(cm[0]), .lane_out_2_o(cm[1]), .lane_out_3_o(cm[2]),
      .lane_out_4_o(cm[3]), .diff_lane_a_o(df[0]), .diff_lane_b_o(df[1]),
      .diff_lane_c_o(df[2]), .diff_lane_d_o(df[3]),
      .forwarded_clock_o(fwd));
   mlr_host_model mlr_host_model_inst (.fwd_clk_i(fwd), .ddr_i(ddr),
      .clr_i(clr), .lane_i(lvds ? df : cm), .cap_o(cap));
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         test_done();
      end
   end
   function automatic logic [63:0] exp_lane(input logic [63:0] w,
                                            input int k);
      for (int i = 0; i < 4; i++) begin
         exp_lane[63-16*i -: 16] = w[16*((k+i)%4) +: 16];
      end
   endfunction
   // Link clock idles low between frames
   task automatic sclk_run(input int n);
      repeat (n) begin
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
   endtask
   task automatic wait_hi(input int b, output logic s);
      s = 1'b0;
      for (int i = 0; i < 200 && !s; i++) begin
         @(posedge clk_i);
         #1 s = (watch[b] === 1'b1);
      end
   endtask
   // Straps change only while strobe high keeps the lanes cleared
   task automatic start(input logic r, input logic l, input logic [63:0] w);
      @(negedge clk_i);
      strobe_n = 1'b1;
      clr = 1'b1;
      ddr = r;
      lvds = l;
      data = w;
      wait_hi(0, seen);
      clr = 1'b0;
      `CHK("sample", 1'b1, seen)
      sclk_run(3);
      @(negedge clk_i);
      strobe_n = 1'b0;
      wait_hi(1, seen);
      `CHK("convert", 1'b1, seen)
      `CHK("busy", 1'b1, busy)
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk_i);
      `CHK("reset", 14'h0000, quiet)
      arst_n_i = 1'b1;
      foreach (rows[r]) begin
         start(rows[r].ddr, rows[r].lvds, rows[r].d);
         wait_hi(2, seen);
         `CHK("valid", 1'b1, seen)
         `CHK("busy", 1'b0, busy)
         sclk_run(rows[r].ddr ? 32 : 65);
         #20;
         for (int k = 0; k < 4; k++) begin
            e = exp_lane(rows[r].d, k);
            `CHK("lane", e, cap[k*64 +: 64])
         end
      end
      start(1'b0, 1'b0, '0);
      repeat (5) @(negedge clk_i);
      strobe_n = 1'b1;
      wait_hi(3, seen);
      `CHK("early", 1'b1, seen)
      wait_hi(2, seen);
      `CHK("valid", 1'b1, seen)
      // Clean start clears the flag; reset mid-conversion quiets all
      @(negedge clk_i);
      strobe_n = 1'b0;
      repeat (4) @(negedge clk_i);
      start(1'b0, 1'b0, 64'h0f0f0f0f0f0f0f0f);
      `CHK("early clear", 1'b0, early)
      repeat (5) @(negedge clk_i);
      arst_n_i = 1'b0;
      @(negedge clk_i);
      `CHK("mid reset", 14'h0000, quiet)
      arst_n_i = 1'b1;
      repeat (2) @(negedge clk_i);
      `CHK("release", 14'h0000, quiet)
      start(1'b0, 1'b0, 64'h0f0f0f0f0f0f0f0f);
      wait_hi(2, seen);
      `CHK("valid", 1'b1, seen)
      test_done();
   end
endmodule
`default_nettype wire
